// [hdl/icf_defs.svh]
/*
 Constants of the fetch unit: control codes, field bits, masks,
 reset values and geometry. Included by the package and the fetch unit module.
*/
`ifndef ICF_DEFS_SVH
`define ICF_DEFS_SVH
`define ICF_RC_CACHE_CTRL 12'h002
`define ICF_RC_ACCESS_A 12'h004
`define ICF_RC_ACCESS_B 12'h005
`define ICF_RC_SRAM_BASE 12'hc04
`define ICF_CACHE_EN_BIT 31
`define ICF_NC_BUF_BIT 10
`define ICF_SRAM_VALID_BIT 0
`define ICF_CACHE_CTRL_MASK 32'h8000_0400
`define ICF_ACCESS_MASK 32'hffff_ffff
`define ICF_SRAM_BASE_MASK 32'hffff_fe01
`define ICF_CACHE_CTRL_RST 32'h0000_0000
`define ICF_ACCESS_RST 32'h0000_0000
`define ICF_SRAM_BASE_RST 32'h0000_0000
`define ICF_NUM_LINES 32
`define ICF_LINE_WORDS 4
`define ICF_TAG_W 23
`define ICF_SRAM_WORDS 128
`endif

// [hdl/icf_fetch_unit.sv]
/*
 Instruction fetch unit: direct-mapped cache with line-fill buffer,
 control registers and the on-chip SRAM on the local bus.
 Assumes one requester per port, all on sys_clk, and an external
 memory port that acknowledges each longword beat.
*/
// Behaviour
// (RULE1) a miss marks the fill buffer as most recently used
// (RULE2) access to the buffer's index bits 8:4 makes the array most recent
// (RULE3) next miss copies buffer to array if line complete and buffer recent
// (RULE4) enabled plus buffering: noncacheable fetches burst into buffer, never array
// (RULE5) cache disabled: every fetch is a single longword access
// (RULE6) enabled: cacheable fetches burst a line, later copyable to array
// (RULE7) enabled, buffering off: noncacheable fetch is one longword, no buffer; code still serves it from the buffer on a buffer hit
// (RULE8) cache and access controls at codes 002, 004, 005, supervisor only
// (RULE9) SRAM is 512 bytes as 128 longwords
// (RULE10) SRAM answers in one cycle, byte, word and longword sizes
// (RULE11) SRAM base is any 512-byte aligned address
// (RULE12) SRAM serves core and debug accesses alike
// (RULE13) fetch inside SRAM region returns SRAM data, cache result dropped
// (RULE14) SRAM data never allocates into the cache
// (RULE15) SRAM base at code c04, supervisor only
// (RULE16) unmapped codes and undefined bits ignore writes, read zero
// (RULE17) software must not rely on uninitialised register contents
// (RULE18) 32 lines of 16 bytes indexed by bits 8:4, one line buffer
`timescale 1ns/1ps
`default_nettype none
`include "icf_defs.svh"
module icf_fetch_unit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic fetchCacheable,
  output logic fetchRdy_r,
  output logic fetchAck_r,
  output logic fetchFromSram_r,
  output logic [31:0] fetchData_r,
  input wire logic dataReq,
  input wire logic dataWrite,
  input wire icf_pkg::icf_size_t dataSize,
  input wire logic [31:0] dataAddr,
  input wire logic [31:0] dataWrData,
  output logic dataAck_r,
  output logic dataMiss_r,
  output logic [31:0] dataRdData_r,
  input wire logic ctlReq,
  input wire logic ctlWrite,
  input wire logic ctlSuper,
  input wire logic [11:0] ctlCode,
  input wire logic [31:0] ctlWrData,
  output logic ctlAck_r,
  output logic ctlPrivErr_r,
  output logic [31:0] ctlRdData_r,
  output logic extReq_r,
  output logic [31:0] extAddr_r,
  output icf_pkg::icf_ext_size_t extSize_r,
  input wire logic extAck,
  input wire logic [31:0] extRdData
);
  icf_pkg::icf_state_t s_r;
  icf_pkg::icf_state_t s_nxt;
  logic cacheEn;
  logic ncBuf;
  logic [4:0] fIdx;
  logic [1:0] fWord;
  logic fetchInSram;
  logic dataInSram;
  logic fbHit;
  logic arrayHit;
  logic takeFetch;
  logic idxTouch;
  logic extPath;
  logic fillStart;
  logic singleStart;
  logic copyNow;
  logic [3:0] byteEn;
  logic [31:0] sramFetchRd;
  logic [31:0] sramDataRd;

  // base bits 31:9 against the address, whole 4 GB range
  function automatic logic in_sram(input logic [31:0] addr, input logic [31:0] base);
    in_sram = base[`ICF_SRAM_VALID_BIT] && (addr[31:9] == base[31:9]);
  endfunction : in_sram

  // big-endian lanes: byte 0 on bits 31:24
  function automatic logic [3:0] lane_en(input icf_pkg::icf_size_t sz, input logic [1:0] a);
    case (sz)
      icf_pkg::ICF_SZ_BYTE: lane_en = 4'h8 >> a;
      icf_pkg::ICF_SZ_WORD: lane_en = a[1] ? 4'h3 : 4'hc;
      default: lane_en = 4'hf;
    endcase
  endfunction : lane_en

  assign cacheEn = s_r.cache_control_reg[`ICF_CACHE_EN_BIT];
  assign ncBuf = s_r.cache_control_reg[`ICF_NC_BUF_BIT];
  // (RULE18) index and word select
  assign fIdx = fetchAddr[8:4];
  assign fWord = fetchAddr[3:2];
  // (RULE11) aligned region decode
  assign fetchInSram = in_sram(fetchAddr, s_r.sramBase);
  assign dataInSram = in_sram(dataAddr, s_r.sramBase);
  assign fbHit = cacheEn && s_r.fbLive && (s_r.fbAddr == fetchAddr[31:4]) && s_r.fbValid[fWord];
  assign arrayHit = cacheEn && fetchCacheable && s_r.lineValid[fIdx]
                    && (s_r.lineTag[fIdx] == fetchAddr[31:9]);
  assign takeFetch = fetchReq && (s_r.fsm == icf_pkg::ICF_IDLE);
  // (RULE2) another line at the buffer's index
  assign idxTouch = takeFetch && s_r.fbLive && (s_r.fbAddr[4:0] == fIdx)
                    && (s_r.fbAddr != fetchAddr[31:4]);
  assign extPath = takeFetch && !fetchInSram && !fbHit && !arrayHit;
  // (RULE4) buffering bit lets noncacheable fetches into the buffer
  assign fillStart = extPath && cacheEn && (fetchCacheable || ncBuf);
  // (RULE5) disabled or unbuffered goes single longword
  assign singleStart = extPath && !(cacheEn && (fetchCacheable || ncBuf));
  // (RULE3) only a complete, recent, allocatable line is copied
  assign copyNow = fillStart && s_r.fbLive && (&s_r.fbValid) && s_r.fbMru
                   && !idxTouch && !s_r.fbNoAlloc;
  assign byteEn = lane_en(dataSize, dataAddr[1:0]);

  // (RULE9) (RULE12) 128 x 32, core or debug alike
  icf_local_sram icf_local_sram_i (
    .sys_clk(sys_clk),
    .wrEn(dataReq && dataWrite && dataInSram),
    .wrAddr(dataAddr[8:2]),
    .wrByteEn(byteEn),
    .wrData(dataWrData),
    .rdAddrA(fetchAddr[8:2]),
    .rdDataA(sramFetchRd),
    .rdAddrB(dataAddr[8:2]),
    .rdDataB(sramDataRd)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fetchAck = 1'b0;
    s_nxt.fetchFromSram = 1'b0;
    s_nxt.dataAck = 1'b0;
    s_nxt.dataMiss = 1'b0;
    s_nxt.ctlAck = 1'b0;
    s_nxt.ctlPrivErr = 1'b0;
    // control register access
    if (ctlReq)
    begin
      s_nxt.ctlAck = 1'b1;
      s_nxt.ctlRdData = 32'h0000_0000;
      // (RULE8) user mode is refused
      if (!ctlSuper)
        s_nxt.ctlPrivErr = 1'b1;
      else if (ctlWrite)
      begin
        // (RULE16) undefined bits masked, unmapped codes ignored
        case (ctlCode)
          `ICF_RC_CACHE_CTRL: s_nxt.cache_control_reg = ctlWrData & `ICF_CACHE_CTRL_MASK;
          `ICF_RC_ACCESS_A: s_nxt.acrA = ctlWrData & `ICF_ACCESS_MASK;
          `ICF_RC_ACCESS_B: s_nxt.acrB = ctlWrData & `ICF_ACCESS_MASK;
          // (RULE15) SRAM base register
          `ICF_RC_SRAM_BASE: s_nxt.sramBase = ctlWrData & `ICF_SRAM_BASE_MASK;
          default: s_nxt.ctlRdData = 32'h0000_0000;
        endcase
      end
      else
      begin
        // (RULE16) unmapped codes read zero
        case (ctlCode)
          `ICF_RC_CACHE_CTRL: s_nxt.ctlRdData = s_r.cache_control_reg;
          `ICF_RC_ACCESS_A: s_nxt.ctlRdData = s_r.acrA;
          `ICF_RC_ACCESS_B: s_nxt.ctlRdData = s_r.acrB;
          `ICF_RC_SRAM_BASE: s_nxt.ctlRdData = s_r.sramBase;
          default: s_nxt.ctlRdData = 32'h0000_0000;
        endcase
      end
    end
    // (RULE10) data access answered next cycle
    if (dataReq)
    begin
      if (dataInSram)
      begin
        s_nxt.dataAck = 1'b1;
        s_nxt.dataRdData = dataWrite ? 32'h0000_0000 : sramDataRd;
      end
      else
        s_nxt.dataMiss = 1'b1;
    end
    case (s_r.fsm)
      icf_pkg::ICF_IDLE:
      begin
        s_nxt.fetchRdy = 1'b1;
        if (takeFetch)
        begin
          if (idxTouch)
            s_nxt.fbMru = 1'b0;
          // (RULE13) SRAM wins; (RULE14) nothing allocated
          if (fetchInSram)
          begin
            s_nxt.fetchAck = 1'b1;
            s_nxt.fetchFromSram = 1'b1;
            s_nxt.fetchData = sramFetchRd;
          end
          else if (fbHit)
          begin
            s_nxt.fetchAck = 1'b1;
            s_nxt.fetchData = s_r.fbData[fWord];
          end
          else if (arrayHit)
          begin
            s_nxt.fetchAck = 1'b1;
            s_nxt.fetchData = s_r.lineData[fIdx][fWord];
          end
          else if (fillStart)
          begin
            // (RULE3) retire the old buffer
            if (copyNow)
            begin
              s_nxt.lineData[s_r.fbAddr[4:0]] = s_r.fbData;
              s_nxt.lineTag[s_r.fbAddr[4:0]] = s_r.fbAddr[27:5];
              s_nxt.lineValid[s_r.fbAddr[4:0]] = 1'b1;
            end
            // (RULE1) new buffer is most recent
            s_nxt.fbMru = 1'b1;
            s_nxt.fbLive = 1'b1;
            s_nxt.fbValid = '0;
            s_nxt.fbAddr = fetchAddr[31:4];
            // (RULE4) noncacheable line stays out of the array
            s_nxt.fbNoAlloc = !fetchCacheable;
            s_nxt.wantWord = fWord;
            s_nxt.beatCnt = 2'h0;
            s_nxt.fetchPend = 1'b1;
            // (RULE6) line burst from the line start
            s_nxt.extReq = 1'b1;
            s_nxt.extAddr = {fetchAddr[31:4], 4'h0};
            s_nxt.extSize = icf_pkg::ICF_EXT_LINE;
            s_nxt.fetchRdy = 1'b0;
            s_nxt.fsm = icf_pkg::ICF_FILL;
          end
          else if (singleStart)
          begin
            // (RULE7) longword, buffer untouched
            s_nxt.extReq = 1'b1;
            s_nxt.extAddr = {fetchAddr[31:2], 2'h0};
            s_nxt.extSize = icf_pkg::ICF_EXT_LONG;
            s_nxt.fetchRdy = 1'b0;
            s_nxt.fsm = icf_pkg::ICF_SINGLE;
          end
        end
      end
      icf_pkg::ICF_FILL:
      begin
        if (extAck)
        begin
          s_nxt.fbData[s_r.beatCnt] = extRdData;
          s_nxt.fbValid[s_r.beatCnt] = 1'b1;
          s_nxt.beatCnt = s_r.beatCnt + 2'h1;
          if (s_r.fetchPend && (s_r.beatCnt == s_r.wantWord))
          begin
            s_nxt.fetchAck = 1'b1;
            s_nxt.fetchData = extRdData;
            s_nxt.fetchPend = 1'b0;
          end
          if (s_r.beatCnt == 2'h3)
          begin
            s_nxt.extReq = 1'b0;
            s_nxt.fetchRdy = 1'b1;
            s_nxt.fsm = icf_pkg::ICF_IDLE;
          end
        end
      end
      icf_pkg::ICF_SINGLE:
      begin
        if (extAck)
        begin
          s_nxt.fetchAck = 1'b1;
          s_nxt.fetchData = extRdData;
          s_nxt.extReq = 1'b0;
          s_nxt.fetchRdy = 1'b1;
          s_nxt.fsm = icf_pkg::ICF_IDLE;
        end
      end
      default:
      begin
        s_nxt.extReq = 1'b0;
        s_nxt.fetchRdy = 1'b1;
        s_nxt.fsm = icf_pkg::ICF_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.fsm <= icf_pkg::ICF_IDLE;
      s_r.cache_control_reg <= `ICF_CACHE_CTRL_RST;
      s_r.acrA <= `ICF_ACCESS_RST;
      s_r.acrB <= `ICF_ACCESS_RST;
      s_r.sramBase <= `ICF_SRAM_BASE_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign fetchRdy_r = s_r.fetchRdy;
  assign fetchAck_r = s_r.fetchAck;
  assign fetchFromSram_r = s_r.fetchFromSram;
  assign fetchData_r = s_r.fetchData;
  assign dataAck_r = s_r.dataAck;
  assign dataMiss_r = s_r.dataMiss;
  assign dataRdData_r = s_r.dataRdData;
  assign ctlAck_r = s_r.ctlAck;
  assign ctlPrivErr_r = s_r.ctlPrivErr;
  assign ctlRdData_r = s_r.ctlRdData;
  assign extReq_r = s_r.extReq;
  assign extAddr_r = s_r.extAddr;
  assign extSize_r = s_r.extSize;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // (RULE1) miss sets recency
  fill_mru_set_a: assert property (fillStart |=> s_r.fbMru && s_r.fbLive && !s_r.fetchRdy) // (RULE1)
    else $error("fill did not mark buffer recent");
  // (RULE2) index access clears recency
  mru_clear_a: assert property (idxTouch && !fillStart |=> !s_r.fbMru) // (RULE2)
    else $error("recency not cleared on index access");
  // (RULE3) array valid bits change only through a guarded copy
  copy_guard_a: assert property ($changed(s_r.lineValid) |-> $past(copyNow)) // (RULE3)
    else $error("array written without copy condition");
  // (RULE4) noncacheable buffer never reaches the array
  nc_noalloc_a: assert property (fillStart && s_r.fbNoAlloc // (RULE4)
    |=> $stable(s_r.lineTag) && $stable(s_r.lineValid))
    else $error("noncacheable line copied into the array");
  // (RULE5) disabled cache issues longwords
  disabled_long_a: assert property (takeFetch && !cacheEn && !fetchInSram // (RULE5)
    |=> s_r.extReq && s_r.extSize == icf_pkg::ICF_EXT_LONG && s_r.fsm == icf_pkg::ICF_SINGLE)
    else $error("disabled cache fetch not a longword");
  // (RULE6) cacheable miss bursts a line
  cache_line_a: assert property (fillStart && fetchCacheable |=> s_r.extSize == icf_pkg::ICF_EXT_LINE // (RULE6)
    && s_r.extAddr[3:0] == 4'h0 && !s_r.fbNoAlloc)
    else $error("cacheable miss not a line burst");
  // (RULE7) unbuffered noncacheable keeps the buffer
  bypass_long_a: assert property (singleStart && cacheEn |=> $stable(s_r.fbAddr) // (RULE7)
    && s_r.extSize == icf_pkg::ICF_EXT_LONG && $stable(s_r.fbValid))
    else $error("unbuffered fetch touched the buffer");
  // (RULE8) user mode refused, state kept
  priv_refuse_a: assert property (ctlReq && !ctlSuper |=> s_r.ctlPrivErr && s_r.ctlRdData == 32'h0 // (RULE8)
    && $stable(s_r.cache_control_reg) && $stable(s_r.sramBase))
    else $error("user access to control register");
  // (RULE11) base alignment held
  base_align_a: assert property (s_r.sramBase[8:1] == 8'h00) // (RULE11)
    else $error("SRAM base not 512-byte aligned");
  // (RULE13) SRAM fetch answered next cycle with SRAM data
  sram_fetch_a: assert property (takeFetch && fetchInSram |=> s_r.fetchAck && s_r.fetchFromSram // (RULE13)
    && s_r.fetchData == $past(sramFetchRd) && $stable(s_r.lineValid))
    else $error("SRAM fetch not served from SRAM");
  // (RULE10) data access single cycle
  sram_single_a: assert property (dataReq && dataInSram |=> s_r.dataAck && !s_r.dataMiss) // (RULE10)
    else $error("SRAM data access not single cycle");
  // (RULE16) unmapped codes read zero
  unmapped_zero_a: assert property (ctlReq && ctlSuper && ctlCode != `ICF_RC_CACHE_CTRL // (RULE16)
    && ctlCode != `ICF_RC_ACCESS_A && ctlCode != `ICF_RC_ACCESS_B && ctlCode != `ICF_RC_SRAM_BASE
    |=> s_r.ctlAck && s_r.ctlRdData == 32'h0 && $stable(s_r.cache_control_reg))
    else $error("unmapped control code not zero");

  fill_seen_c: cover property (fillStart ##1 s_r.fsm == icf_pkg::ICF_FILL [*5] ##1 s_r.fetchRdy);
  copy_seen_c: cover property (copyNow);
  fb_hit_c: cover property (takeFetch && fbHit && !fetchInSram);
  sram_fetch_c: cover property (takeFetch && fetchInSram && arrayHit);
endmodule : icf_fetch_unit
`default_nettype wire

// [hdl/icf_local_sram.sv]
/*
 On-chip SRAM array, 128 longwords, one write port with byte
 enables and two combinational read ports. Contents are not reset.
*/
`timescale 1ns/1ps
`default_nettype none
module icf_local_sram (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [3:0] wrByteEn,
  input wire logic [31:0] wrData,
  input wire logic [6:0] rdAddrA,
  output logic [31:0] rdDataA,
  input wire logic [6:0] rdAddrB,
  output logic [31:0] rdDataB
);
  icf_pkg::icf_sram_state_t s_r;
  icf_pkg::icf_sram_state_t s_nxt;

  assign rdDataA = s_r.mem[rdAddrA];
  assign rdDataB = s_r.mem[rdAddrB];

  always_comb
  begin
    s_nxt = s_r;
    if (wrEn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wrByteEn[i])
          s_nxt.mem[wrAddr][8*i +: 8] = wrData[8*i +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_r <= s_nxt;
  end
endmodule : icf_local_sram
`default_nettype wire

// [hdl/icf_pkg.sv]
/*
 Types of the fetch unit: states, sizes and the state records.
 Assumes icf_defs.svh is on the include path.
*/
`include "icf_defs.svh"
package icf_pkg;
  typedef enum logic [1:0] {ICF_IDLE, ICF_FILL, ICF_SINGLE} icf_fsm_t;
  typedef enum logic {ICF_EXT_LONG, ICF_EXT_LINE} icf_ext_size_t;
  typedef enum logic [1:0] {ICF_SZ_BYTE, ICF_SZ_WORD, ICF_SZ_LONG} icf_size_t;

  typedef struct packed {
    logic [`ICF_SRAM_WORDS-1:0][31:0] mem;
  } icf_sram_state_t;

  typedef struct packed {
    icf_fsm_t fsm;
    logic [31:0] cache_control_reg;
    logic [31:0] acrA;
    logic [31:0] acrB;
    logic [31:0] sramBase;
    logic [`ICF_NUM_LINES-1:0][`ICF_LINE_WORDS-1:0][31:0] lineData;
    logic [`ICF_NUM_LINES-1:0][`ICF_TAG_W-1:0] lineTag;
    logic [`ICF_NUM_LINES-1:0] lineValid;
    logic [`ICF_LINE_WORDS-1:0][31:0] fbData;
    logic [27:0] fbAddr;
    logic [`ICF_LINE_WORDS-1:0] fbValid;
    logic fbMru;
    logic fbNoAlloc;
    logic fbLive;
    logic [1:0] wantWord;
    logic [1:0] beatCnt;
    logic fetchPend;
    logic fetchRdy;
    logic fetchAck;
    logic fetchFromSram;
    logic [31:0] fetchData;
    logic extReq;
    logic [31:0] extAddr;
    icf_ext_size_t extSize;
    logic dataAck;
    logic dataMiss;
    logic [31:0] dataRdData;
    logic ctlAck;
    logic ctlPrivErr;
    logic [31:0] ctlRdData;
  } icf_state_t;
endpackage : icf_pkg

// [tb/icache_fill_buffer_and_local_sram_bench.sv]
/*
 Self-checking bench of the fetch unit: control codes, fetch sizing,
 fill buffer recency and the local SRAM. Assumes the memory model
 answers every beat after the latency set here.
*/
`timescale 1ns/1ps
`default_nettype none
module icache_fill_buffer_and_local_sram_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic fetchReq = 1'b0, fetchCacheable = 1'b0, dataReq = 1'b0, dataWrite = 1'b0;
  logic ctlReq = 1'b0, ctlWrite = 1'b0, ctlSuper = 1'b0;
  logic [31:0] fetchAddr = 32'h0, dataAddr = 32'h0, dataWrData = 32'h0, ctlWrData = 32'h0;
  logic [11:0] ctlCode = 12'h0;
  icf_pkg::icf_size_t dataSize = icf_pkg::ICF_SZ_LONG;
  logic [3:0] latency = 4'h0;
  logic fetchRdy_r, fetchAck_r, fetchFromSram_r, dataAck_r, dataMiss_r, ctlAck_r, ctlPrivErr_r;
  logic extReq_r, extAck;
  logic [31:0] fetchData_r, dataRdData_r, ctlRdData_r, extAddr_r, extRdData;
  icf_pkg::icf_ext_size_t extSize_r;
  int failCount = 0, checksDone = 0;
  logic [31:0] rd, ea, expSram;
  logic err, fs, ex, sz;

  always #2.5 sys_clk = ~sys_clk;

  icf_fetch_unit icf_fetch_unit_i (
    .sys_clk, .rst, .fetchReq, .fetchAddr, .fetchCacheable, .fetchRdy_r, .fetchAck_r,
    .fetchFromSram_r, .fetchData_r, .dataReq, .dataWrite, .dataSize, .dataAddr, .dataWrData,
    .dataAck_r, .dataMiss_r, .dataRdData_r, .ctlReq, .ctlWrite, .ctlSuper, .ctlCode, .ctlWrData,
    .ctlAck_r, .ctlPrivErr_r, .ctlRdData_r, .extReq_r, .extAddr_r, .extSize_r, .extAck, .extRdData
  );
  icf_ext_mem_model icf_ext_mem_model_i (
    .sys_clk, .rst, .latency, .extReq_r, .extAddr_r, .extSize_r, .extAck, .extRdData
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic ctl(input logic w, input logic s, input logic [11:0] code, input logic [31:0] wd);
    @(posedge sys_clk);
    ctlReq <= 1'b1;
    ctlWrite <= w;
    ctlSuper <= s;
    ctlCode <= code;
    ctlWrData <= wd;
    @(posedge sys_clk);
    ctlReq <= 1'b0;
    #1;
    chk("ctlAck", 32'h1, {31'h0, ctlAck_r});
    rd = ctlRdData_r;
    err = ctlPrivErr_r;
  endtask : ctl

  task automatic wr_rd(input logic [11:0] code, input logic [31:0] wd, input logic [31:0] exp);
    ctl(1'b1, 1'b1, code, wd);
    ctl(1'b0, 1'b1, code, 32'h0);
    chk("ctlRead", exp, rd);
  endtask : wr_rd

  task automatic dat(input logic w, input icf_pkg::icf_size_t s, input logic [31:0] a,
                     input logic [31:0] wd, input logic hit);
    @(posedge sys_clk);
    dataReq <= 1'b1;
    dataWrite <= w;
    dataSize <= s;
    dataAddr <= a;
    dataWrData <= wd;
    @(posedge sys_clk);
    dataReq <= 1'b0;
    #1;
    chk("dataAck", {31'h0, hit}, {31'h0, dataAck_r});
    chk("dataMiss", {31'h0, ~hit}, {31'h0, dataMiss_r});
    rd = dataRdData_r;
  endtask : dat

  // xe: external access expected, xs: line sized, xm: served by SRAM
  task automatic fetch(input logic [31:0] a, input logic c, input logic xe, input logic xs,
                       input logic xm);
    int n;
    chk("fetchRdy", 32'h1, {31'h0, fetchRdy_r});
    @(posedge sys_clk);
    fetchReq <= 1'b1;
    fetchAddr <= a;
    fetchCacheable <= c;
    @(posedge sys_clk);
    fetchReq <= 1'b0;
    ex = 1'b0;
    for (n = 0; n < 60; n++)
    begin
      #1;
      if (extReq_r === 1'b1 && !ex)
      begin
        ex = 1'b1;
        sz = extSize_r;
        ea = extAddr_r;
      end
      if (fetchAck_r === 1'b1)
        break;
      @(posedge sys_clk);
    end
    fs = fetchFromSram_r;
    rd = fetchData_r;
    for (; n < 60 && extReq_r !== 1'b0; n++)
      @(posedge sys_clk) #1;
    if (n >= 60)
    begin
      failCount++;
      end_of_test();
    end
    chk("fetchData", xm ? expSram : ({a[31:2], 2'h0} ^ 32'h3c5a_0000), rd);
    chk("extUsed", {31'h0, xe}, {31'h0, ex});
    chk("fromSram", {31'h0, xm}, {31'h0, fs});
    if (xe)
    begin
      chk("extSize", {31'h0, xs}, {31'h0, sz});
      chk("extAddr", xs ? {a[31:4], 4'h0} : a, ea);
    end
  endtask : fetch

  task automatic test_ctl;
    wr_rd(12'h002, 32'hffff_ffff, 32'h8000_0400);
    wr_rd(12'h004, 32'h1234_5678, 32'h1234_5678);
    wr_rd(12'h005, 32'h8765_4321, 32'h8765_4321);
    wr_rd(12'hc04, 32'hffff_ffff, 32'hffff_fe01);
    wr_rd(12'h003, 32'hffff_ffff, 32'h0);
    ctl(1'b1, 1'b0, 12'h002, 32'h0);
    chk("privErr", 32'h1, {31'h0, err});
    ctl(1'b0, 1'b0, 12'hc04, 32'h0);
    chk("userRead", 32'h0, rd);
    chk("userErr", 32'h1, {31'h0, err});
    ctl(1'b0, 1'b1, 12'h002, 32'h0);
    chk("ctrlKept", 32'h8000_0400, rd);
    $display("test ctl done");
  endtask : test_ctl

  task automatic test_sizes;
    wr_rd(12'h002, 32'h0000_0400, 32'h0000_0400);
    fetch(32'h1000_0108, 1'b1, 1'b1, 1'b0, 1'b0);
    wr_rd(12'h002, 32'h8000_0000, 32'h8000_0000);
    fetch(32'h4000_0044, 1'b0, 1'b1, 1'b0, 1'b0);
    fetch(32'h4000_0044, 1'b0, 1'b1, 1'b0, 1'b0);
    wr_rd(12'h002, 32'h8000_0400, 32'h8000_0400);
    fetch(32'h4000_0044, 1'b0, 1'b1, 1'b1, 1'b0);
    fetch(32'h4000_0048, 1'b0, 1'b0, 1'b0, 1'b0);
    fetch(32'h4000_0100, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h4000_0048, 1'b1, 1'b1, 1'b1, 1'b0);
    $display("test sizes done");
  endtask : test_sizes

  task automatic test_recency;
    latency <= 4'h3;
    wr_rd(12'h002, 32'h8000_0000, 32'h8000_0000);
    fetch(32'h2000_0018, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_001c, 1'b1, 1'b0, 1'b0, 1'b0);
    fetch(32'h2000_0028, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0014, 1'b1, 1'b0, 1'b0, 1'b0);
    fetch(32'h2000_0228, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0028, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0040, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0228, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0024, 1'b1, 1'b0, 1'b0, 1'b0);
    fetch(32'h2000_0060, 1'b1, 1'b1, 1'b1, 1'b0);
    fetch(32'h2000_0228, 1'b1, 1'b1, 1'b1, 1'b0);
    latency <= 4'h0;
    $display("test recency done");
  endtask : test_recency

  task automatic test_sram;
    dat(1'b1, icf_pkg::ICF_SZ_LONG, 32'hffff_fffc, 32'hcafe_f00d, 1'b1);
    dat(1'b0, icf_pkg::ICF_SZ_LONG, 32'hffff_fffc, 32'h0, 1'b1);
    chk("sramTop", 32'hcafe_f00d, rd);
    wr_rd(12'hc04, 32'h5000_0001, 32'h5000_0001);
    dat(1'b1, icf_pkg::ICF_SZ_LONG, 32'h5000_0000, 32'h0, 1'b1);
    dat(1'b1, icf_pkg::ICF_SZ_BYTE, 32'h5000_0001, 32'h00ab_0000, 1'b1);
    dat(1'b1, icf_pkg::ICF_SZ_WORD, 32'h5000_0002, 32'h0000_beef, 1'b1);
    dat(1'b0, icf_pkg::ICF_SZ_LONG, 32'h5000_0000, 32'h0, 1'b1);
    chk("sramLanes", 32'h00ab_beef, rd);
    dat(1'b1, icf_pkg::ICF_SZ_LONG, 32'h5000_01fc, 32'h1122_3344, 1'b1);
    dat(1'b0, icf_pkg::ICF_SZ_LONG, 32'h5000_01fc, 32'h0, 1'b1);
    chk("sramLast", 32'h1122_3344, rd);
    dat(1'b0, icf_pkg::ICF_SZ_LONG, 32'h5000_0200, 32'h0, 1'b0);
    expSram = 32'h1122_3344;
    wr_rd(12'h002, 32'h8000_0000, 32'h8000_0000);
    fetch(32'h5000_01fc, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_rd(12'hc04, 32'h2000_0001, 32'h2000_0001);
    dat(1'b1, icf_pkg::ICF_SZ_LONG, 32'h2000_0014, 32'h0bad_cafe, 1'b1);
    expSram = 32'h0bad_cafe;
    fetch(32'h2000_0014, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_rd(12'hc04, 32'h0, 32'h0);
    fetch(32'h5000_01fc, 1'b1, 1'b1, 1'b1, 1'b0);
    $display("test sram done");
  endtask : test_sram

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    test_ctl();
    test_sizes();
    test_recency();
    test_sram();
    end_of_test();
  end
endmodule : icache_fill_buffer_and_local_sram_bench
`default_nettype wire

// [tb/icf_ext_mem_model.sv]
/*
 External memory model for the fetch unit's longword and line port.
 Assumes extReq_r holds until the edge of the last extAck.
*/
`timescale 1ns/1ps
`default_nettype none
module icf_ext_mem_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] latency,
  input wire logic extReq_r,
  input wire logic [31:0] extAddr_r,
  input wire icf_pkg::icf_ext_size_t extSize_r,
  output logic extAck,
  output logic [31:0] extRdData
);
  logic [2:0] beat;
  logic [3:0] waitCnt;
  logic [31:0] addr;
  assign addr = extAddr_r + {27'h0, beat, 2'h0};
  always @(posedge sys_clk)
  begin
    if (rst || !extReq_r)
    begin
      extAck <= 1'b0;
      // idle bus toggles so a stale word never passes
      extRdData <= rst ? 32'h0 : ~extRdData;
      beat <= 3'h0;
      waitCnt <= 4'h0;
    end
    else if (waitCnt == latency && beat < ((extSize_r == icf_pkg::ICF_EXT_LINE) ? 3'h4 : 3'h1))
    begin
      extAck <= 1'b1;
      extRdData <= {addr[31:2], 2'h0} ^ 32'h3c5a_0000;
      beat <= beat + 3'h1;
      waitCnt <= 4'h0;
    end
    else
    begin
      extAck <= 1'b0;
      extRdData <= ~extRdData;
      if (waitCnt != latency)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : icf_ext_mem_model
`default_nettype wire
